// >>> rtl/bfam_top.sv
// fault action manager: gate disable, fault latches, diag bits, axi4-lite regs
// Functional notes
// - power-on reset, regulator or main supply undervoltage forces all gates off, unlatched.
// - enabled watchdog timeout forces all gates off until watchdog is reset.
// - logic overvoltage or overtemperature turns all gates off only when stop_on_fault set.
// - drain-source or bootstrap fault with stop_on_fault latches all gates off.
// - same faults without stop_on_fault latch only that gate, cleared by next switch-on.
// - all remaining faults leave the gate drive outputs enabled.
// - unlatched states exist only during detection; latched ones persist until reset.
// - latched states clear on clear input low, power-on reset or diag read.
// - diag bits clear only on power-on reset or diag read, not clear input.
// - a set mask bit fully disables its diagnostic.
// - power-on reset, serial error and overtemperature cannot be masked.
// - off-line verification runs only when the controller commands it.
`timescale 1ns/100ps
module bfam_top #(
  parameter int VC_W = 8,
  parameter int VR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              ce_in,
  input  wire logic              por_in,
  input  wire logic              reg_uv_in,
  input  wire logic              main_uv_in,
  input  wire logic              wdog_to_in,
  input  wire logic              logic_ov_in,
  input  wire logic              otemp_in,
  input  wire logic [3:0]        ds_fault_in,
  input  wire logic [1:0]        boot_uv_in,
  input  wire logic              ser_err_in,
  input  wire logic              reg_ov_in,
  input  wire logic              main_ov_in,
  input  wire logic              gs_uv_in,
  input  wire logic              temp_warn_in,
  input  wire logic              ocur_in,
  input  wire logic              open_load_in,
  input  wire logic              external_clear_input_b_in,
  input  wire logic [3:0]        gate_cmd_in,
  input  wire logic [VR_W-1:0]   online_res_in,
  output logic      [3:0]        gate_en_out,
  output logic      [VC_W-1:0]   verify_cmd_out,
  input  wire logic              axi_awvalid_in,
  output logic                   axi_awready_out,
  input  wire logic [7:0]        axi_awaddr_in,
  input  wire logic              axi_wvalid_in,
  output logic                   axi_wready_out,
  input  wire logic [31:0]       axi_wdata_in,
  input  wire logic [3:0]        axi_wstrb_in,
  output logic                   axi_bvalid_out,
  input  wire logic              axi_bready_in,
  output logic      [1:0]        axi_bresp_out,
  input  wire logic              axi_arvalid_in,
  output logic                   axi_arready_out,
  input  wire logic [7:0]        axi_araddr_in,
  output logic                   axi_rvalid_out,
  input  wire logic              axi_rready_in,
  output logic      [31:0]       axi_rdata_out,
  output logic      [1:0]        axi_rresp_out
);
  import bfam_pkg::*;

  if (VC_W < 1 || VC_W > 32 || VR_W < 1 || VR_W > 32) begin : g_chk
    $error("bfam_top: VC_W and VR_W must be 1 to 32");
  end

  typedef struct packed {
    logic [CTL_W-1:0]  ctrl_r;
    logic [MASK_W-1:0] mask_r;
    logic [31:0]       diag_r;
    logic              lat_all_r;
    logic [3:0]        lat_fet_r;
    logic [3:0]        cmd_prev_r;
    logic [3:0]        gate_r;
    logic [VC_W-1:0]   vcmd_r;
    logic              aw_have_r;
    logic [7:0]        awaddr_r;
    logic              w_have_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
  } bfam_state_t;

  logic [1:0]  rst_sync_r;
  logic        rst_q_b;
  bfam_state_t s_r;
  bfam_state_t s_nxt;

  logic        stop_on_fault;
  logic        enable_watchdog_monitor;
  logic        reg_uv_v;
  logic        main_uv_v;
  logic        wdog_v;
  logic        logic_ov_v;
  logic [3:0]  ds_v;
  logic [1:0]  boot_v;
  logic [3:0]  fet_ev;
  logic [31:0] diag_set;
  logic        dis_all;
  logic        clr_lat;
  logic        rd_diag;
  logic        ar_hs;
  logic        wr_go;
  logic [3:0]  cmd_rise;

  // merge write data into a register under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // true when a byte address names a register
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_MASK) || (a == OFS_DIAG) ||
           (a == OFS_STAT) || (a == OFS_VCMD) || (a == OFS_VRES);
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q_b = rst_sync_r[1];

  // masked fault events
  assign stop_on_fault           = s_r.ctrl_r[CTL_STOP];
  assign enable_watchdog_monitor = s_r.ctrl_r[CTL_WDOG];
  assign reg_uv_v   = reg_uv_in & ~s_r.mask_r[MK_REG_UV];
  assign main_uv_v  = main_uv_in & ~s_r.mask_r[MK_MAIN_U];
  assign wdog_v     = wdog_to_in & enable_watchdog_monitor & ~s_r.mask_r[MK_WDOG];
  assign logic_ov_v = logic_ov_in & ~s_r.mask_r[MK_LOG_OV];
  assign ds_v       = ds_fault_in & ~{4{s_r.mask_r[MK_DSV]}};
  assign boot_v     = boot_uv_in & ~{2{s_r.mask_r[MK_BOOT]}};
  // bootstrap faults belong to the high-side fets (0 and 2)
  assign fet_ev     = ds_v | {1'b0, boot_v[1], 1'b0, boot_v[0]};

  // sticky diag sources; power-on, serial error, overtemp are never masked
  assign diag_set = {10'h000, boot_v, ds_v, 3'h0,
                     open_load_in & ~s_r.mask_r[MK_OPEN],
                     ocur_in & ~s_r.mask_r[MK_OCUR],
                     temp_warn_in & ~s_r.mask_r[MK_TWARN],
                     gs_uv_in & ~s_r.mask_r[MK_GS_UV],
                     main_ov_in & ~s_r.mask_r[MK_MAIN_O],
                     reg_ov_in & ~s_r.mask_r[MK_REG_OV],
                     ser_err_in, main_uv_v, otemp_in, wdog_v,
                     logic_ov_v, reg_uv_v, por_in};

  // bridge-wide disable terms, all unlatched except lat_all_r
  assign dis_all = por_in | reg_uv_v
                 | wdog_v
                 | (stop_on_fault & (logic_ov_v | otemp_in))
                 | main_uv_v
                 | (stop_on_fault & (|fet_ev)) | s_r.lat_all_r;

  // bus handshakes
  assign ar_hs   = axi_arvalid_in & axi_arready_out;
  assign rd_diag = ar_hs & (axi_araddr_in == OFS_DIAG);
  assign wr_go   = s_r.aw_have_r & s_r.w_have_r & ~s_r.bvalid_r;
  assign clr_lat = ~external_clear_input_b_in | por_in | rd_diag;
  assign cmd_rise = gate_cmd_in & ~s_r.cmd_prev_r;

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // latched fault states; a new event wins over any clear
    s_nxt.lat_all_r = (s_r.lat_all_r & ~clr_lat) | (stop_on_fault & (|fet_ev));
    s_nxt.lat_fet_r = (s_r.lat_fet_r & ~(clr_lat ? 4'hF : cmd_rise))
                    | ({4{~stop_on_fault}} & fet_ev);
    s_nxt.cmd_prev_r = gate_cmd_in;
    // gate enables follow commands unless disabled
    s_nxt.gate_r = gate_cmd_in & ~{4{dis_all}} & ~s_nxt.lat_fet_r;
    // diag bits: clear only by read or power-on, set wins
    s_nxt.diag_r = ((rd_diag | por_in) ? 32'h0000_0000 : s_r.diag_r) | diag_set;
    // write address and data channels, taken in either order
    if (axi_awvalid_in && axi_awready_out) begin
      s_nxt.aw_have_r = 1'b1;
      s_nxt.awaddr_r  = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out) begin
      s_nxt.w_have_r = 1'b1;
      s_nxt.wdata_r  = axi_wdata_in;
      s_nxt.wstrb_r  = axi_wstrb_in;
    end
    if (wr_go) begin
      s_nxt.aw_have_r = 1'b0;
      s_nxt.w_have_r  = 1'b0;
      s_nxt.bvalid_r  = 1'b1;
      s_nxt.bresp_r   = addr_ok(s_r.awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_r.awaddr_r)
        OFS_CTRL: begin
          s_nxt.ctrl_r = CTL_W'(strb_merge(32'(s_r.ctrl_r), s_r.wdata_r, s_r.wstrb_r));
        end
        OFS_MASK: begin
          s_nxt.mask_r = MASK_W'(strb_merge(32'(s_r.mask_r), s_r.wdata_r, s_r.wstrb_r));
        end
        OFS_VCMD: begin
          s_nxt.vcmd_r = VC_W'(strb_merge(32'(s_r.vcmd_r), s_r.wdata_r, s_r.wstrb_r));
        end
        default: begin
        end
      endcase
    end
    if (s_r.bvalid_r && axi_bready_in) begin
      s_nxt.bvalid_r = 1'b0;
    end
    // read channel
    if (s_r.rvalid_r && axi_rready_in) begin
      s_nxt.rvalid_r = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid_r = 1'b1;
      s_nxt.rresp_r  = addr_ok(axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
      unique case (axi_araddr_in)
        OFS_CTRL: s_nxt.rdata_r = 32'(s_r.ctrl_r);
        OFS_MASK: s_nxt.rdata_r = 32'(s_r.mask_r);
        OFS_DIAG: s_nxt.rdata_r = s_r.diag_r;
        OFS_STAT: begin
          s_nxt.rdata_r = 32'h0000_0000;
          s_nxt.rdata_r[ST_DIS]       = dis_all;
          s_nxt.rdata_r[ST_LATA]      = s_r.lat_all_r;
          s_nxt.rdata_r[ST_LATF +: 4] = s_r.lat_fet_r;
          s_nxt.rdata_r[ST_GATE +: 4] = s_r.gate_r;
        end
        OFS_VCMD: s_nxt.rdata_r = 32'(s_r.vcmd_r);
        OFS_VRES: s_nxt.rdata_r = 32'(online_res_in);
        default:  s_nxt.rdata_r = 32'h0000_0000;
      endcase
    end
  end

  // state register, frozen while ce_in is low
  always_ff @(posedge clk_in or negedge rst_q_b) begin
    if (!rst_q_b) begin
      s_r <= '{ctrl_r: CTRL_RST, mask_r: MASK_RST, default: '0};
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign gate_en_out     = s_r.gate_r;
  assign verify_cmd_out  = s_r.vcmd_r;
  assign axi_awready_out = ~s_r.aw_have_r & ~s_r.bvalid_r;
  assign axi_wready_out  = ~s_r.w_have_r & ~s_r.bvalid_r;
  assign axi_bvalid_out  = s_r.bvalid_r;
  assign axi_bresp_out   = s_r.bresp_r;
  assign axi_arready_out = ~s_r.rvalid_r;
  assign axi_rvalid_out  = s_r.rvalid_r;
  assign axi_rdata_out   = s_r.rdata_r;
  assign axi_rresp_out   = s_r.rresp_r;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_q_b);

  sequence fet0_rearm_s;
    ce_in && !stop_on_fault && s_r.lat_fet_r[0] && gate_cmd_in[0] && !s_r.cmd_prev_r[0];
  endsequence
  sequence fet0_quiet_s;
    !fet_ev[0] && !dis_all;
  endsequence

  por_gates_off_a: assert property (ce_in && (por_in || reg_uv_v) |=> gate_en_out == 4'h0)
    else $error("gates on during power-on or regulator undervoltage");
  wdog_gates_off_a: assert property (ce_in && enable_watchdog_monitor && wdog_to_in
      && !s_r.mask_r[MK_WDOG] |=> gate_en_out == 4'h0)
    else $error("gates on during watchdog timeout");
  stop_ov_off_a: assert property (ce_in && stop_on_fault && (otemp_in || logic_ov_v)
      |=> gate_en_out == 4'h0)
    else $error("gates on during overtemperature with stop set");
  main_uv_off_a: assert property (ce_in && main_uv_v |=> gate_en_out == 4'h0)
    else $error("gates on during main supply undervoltage");
  latch_all_hold_a: assert property (ce_in && stop_on_fault && ds_v[1]
      ##1 (ce_in && !clr_lat)[*2] |=> s_r.lat_all_r && gate_en_out == 4'h0)
    else $error("latched bridge fault released early");
  fet_rearm_a: assert property (fet0_rearm_s ##0 fet0_quiet_s
      |=> !s_r.lat_fet_r[0] && gate_en_out[0])
    else $error("fet latch not cleared by switch-on");
  minor_pass_a: assert property (ce_in && !dis_all && s_nxt.lat_fet_r == 4'h0
      |=> gate_en_out == $past(gate_cmd_in))
    else $error("gate blocked by a minor fault");
  // a fresh latching event in the clear cycle wins, so only that case is left out
  clear_in_a: assert property (ce_in && !external_clear_input_b_in
      && !(stop_on_fault && (|fet_ev)) |=> !s_r.lat_all_r)
    else $error("clear input did not reset latch");
  diag_keep_a: assert property (ce_in && !rd_diag && !por_in
      |=> (s_r.diag_r & $past(s_r.diag_r)) == $past(s_r.diag_r))
    else $error("diag bit lost without read");
  // bootstrap faults share the latches, so they are left out here
  mask_ds_a: assert property (ce_in && s_r.mask_r[MK_DSV] && boot_v == 2'h0
      |=> (s_r.lat_fet_r & ~$past(s_r.lat_fet_r)) == 4'h0
      && (!s_r.lat_all_r || $past(s_r.lat_all_r)))
    else $error("masked fault changed latch");
  otemp_bit_a: assert property (ce_in && otemp_in |=> s_r.diag_r[DG_OTEMP])
    else $error("overtemperature bit not set");
  vcmd_hold_a: assert property (!wr_go |=> $stable(verify_cmd_out))
    else $error("verify command changed without a write");
endmodule

// >>> common/bfam_pkg.sv
// constants for the bridge fault action manager
package bfam_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_VCMD = 8'h10;
  localparam logic [7:0] OFS_VRES = 8'h14;
  // control fields
  localparam int CTL_STOP = 0;
  localparam int CTL_WDOG = 1;
  localparam int CTL_W    = 2;
  // mask fields
  localparam int MK_REG_UV = 0;
  localparam int MK_BOOT   = 1;
  localparam int MK_LOG_OV = 2;
  localparam int MK_WDOG   = 3;
  localparam int MK_DSV    = 4;
  localparam int MK_MAIN_U = 5;
  localparam int MK_REG_OV = 6;
  localparam int MK_MAIN_O = 7;
  localparam int MK_GS_UV  = 8;
  localparam int MK_TWARN  = 9;
  localparam int MK_OCUR   = 10;
  localparam int MK_OPEN   = 11;
  localparam int MASK_W    = 12;
  // diagnostic bit positions
  localparam int DG_POR   = 0;
  localparam int DG_OTEMP = 4;
  localparam int DG_DSV   = 16;
  localparam int DG_BOOT  = 20;
  // status fields
  localparam int ST_DIS  = 0;
  localparam int ST_LATA = 1;
  localparam int ST_LATF = 4;
  localparam int ST_GATE = 8;
  // reset values and responses
  localparam logic [CTL_W-1:0]  CTRL_RST = 2'h0;
  localparam logic [MASK_W-1:0] MASK_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> sim/bfam_ctl.sv
// controller model: axi4-lite master that the bench drives through its tasks
`timescale 1ns/100ps
module bfam_ctl (
  input  wire logic        clk_in,
  output logic             awv_out,
  input  wire logic        awr_in,
  output logic [7:0]       awa_out,
  output logic             wv_out,
  input  wire logic        wr_in,
  output logic [31:0]      wd_out,
  output logic [3:0]       ws_out,
  input  wire logic        bv_in,
  output logic             br_out,
  input  wire logic [1:0]  bp_in,
  output logic             arv_out,
  input  wire logic        arr_in,
  output logic [7:0]       ara_out,
  input  wire logic        rv_in,
  output logic             rr_out,
  input  wire logic [31:0] rd_in,
  input  wire logic [1:0]  rp_in
);
  // idle bus at time zero, full-word strobes
  initial begin
    {awv_out, wv_out, br_out, arv_out, rr_out} = 5'h00;
    {awa_out, ara_out} = 16'h0000;
    wd_out = 32'h00000000;
    ws_out = 4'hF;
  end
  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap;
    logic dp;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge clk_in);
    awa_out <= a;
    wd_out  <= d;
    awv_out <= 1'b1;
    wv_out  <= 1'b1;
    br_out  <= 1'b1;
    while (ap || dp) begin
      @(posedge clk_in);
      if (awr_in) ap = 1'b0;
      if (wr_in) dp = 1'b0;
      awv_out <= ap;
      wv_out  <= dp;
    end
    while (!bv_in) @(posedge clk_in);
    r = bp_in;
    br_out <= 1'b0;
  endtask
  // one read: address held until taken, data taken with the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    ara_out <= a;
    arv_out <= 1'b1;
    rr_out  <= 1'b1;
    do @(posedge clk_in); while (!arr_in);
    arv_out <= 1'b0;
    while (!rv_in) @(posedge clk_in);
    d = rd_in;
    r = rp_in;
    rr_out <= 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// bench for the bridge fault action manager
`timescale 1ns/100ps
module testbench;
  import bfam_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_b_in;
  logic        clr_b;
  logic        ce;
  logic        wdog;
  logic [4:0]  flt;
  logic [6:0]  oth;
  logic [3:0]  dsf, cmd, gate, ws;
  logic [1:0]  boot, bp, rp, resp;
  logic [7:0]  vcmd, awa, ara;
  logic [31:0] wd, rdt, rd_d;
  logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  int          errors;
  int          comparisons;

  bfam_top u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .por_in(flt[0]),
    .reg_uv_in(flt[1]), .main_uv_in(flt[2]), .wdog_to_in(wdog), .logic_ov_in(flt[3]),
    .otemp_in(flt[4]), .ds_fault_in(dsf), .boot_uv_in(boot), .ser_err_in(oth[0]),
    .reg_ov_in(oth[1]), .main_ov_in(oth[2]), .gs_uv_in(oth[3]), .temp_warn_in(oth[4]),
    .ocur_in(oth[5]), .open_load_in(oth[6]), .external_clear_input_b_in(clr_b),
    .gate_cmd_in(cmd), .online_res_in(8'h3C), .gate_en_out(gate), .verify_cmd_out(vcmd),
    .axi_awvalid_in(awv), .axi_awready_out(awr), .axi_awaddr_in(awa), .axi_wvalid_in(wv),
    .axi_wready_out(wrd), .axi_wdata_in(wd), .axi_wstrb_in(ws), .axi_bvalid_out(bv),
    .axi_bready_in(br), .axi_bresp_out(bp), .axi_arvalid_in(arv), .axi_arready_out(arr),
    .axi_araddr_in(ara), .axi_rvalid_out(rv), .axi_rready_in(rr), .axi_rdata_out(rdt),
    .axi_rresp_out(rp)
  );
  bfam_ctl u_ctl (
    .clk_in(clk_in), .awv_out(awv), .awr_in(awr), .awa_out(awa), .wv_out(wv), .wr_in(wrd),
    .wd_out(wd), .ws_out(ws), .bv_in(bv), .br_out(br), .bp_in(bp), .arv_out(arv),
    .arr_in(arr), .ara_out(ara), .rv_in(rv), .rr_out(rr), .rd_in(rdt), .rp_in(rp)
  );

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  // compare and count
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // let the inputs land, then look at the gate enables
  task automatic gchk(input logic [3:0] e);
    repeat (3) @(posedge clk_in);
    #1;
    check("gate_en", {28'h0, gate}, {28'h0, e});
    @(posedge clk_in);
  endtask
  // register read with expected data and response
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] ep);
    u_ctl.rd(a, rd_d, resp);
    check(n, rd_d, e);
    check("rresp", {30'h0, resp}, {30'h0, ep});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    u_ctl.wr(a, d, resp);
  endtask
  // one verdict for the whole run
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    rst_b_in = 1'b0;
    clr_b = 1'b1;
    ce = 1'b1;
    {wdog, flt, oth, dsf, boot} = '0;
    cmd = 4'hF;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check("verify_cmd", {24'h0, vcmd}, 32'h0);
    // remaining faults keep the gates running but still flag their bit
    for (int i = 0; i < 7; i++) begin
      oth <= 7'h01 << i;
      gchk(4'hF);
      oth <= 7'h00;
      rchk("diag", OFS_DIAG, 32'h40 << i, RESP_OKAY);
    end
    // unlatched faults under both stop settings
    for (int s = 0; s < 2; s++) begin
      wreg(OFS_CTRL, 32'(s));
      for (int i = 0; i < 5; i++) begin
        flt <= 5'h01 << i;
        gchk((i < 3 || s == 1) ? 4'h0 : 4'hF);
        flt <= 5'h00;
        gchk(4'hF);
      end
    end
    // watchdog acts only when enabled
    wdog <= 1'b1;
    gchk(4'hF);
    wreg(OFS_CTRL, 32'h2);
    gchk(4'h0);
    wdog <= 1'b0;
    gchk(4'hF);
    // stop set: latched all-off, cleared by clear input, bit survives
    wreg(OFS_CTRL, 32'h1);
    rchk("diag", OFS_DIAG, 32'h3F, RESP_OKAY);
    dsf <= 4'h2;
    @(posedge clk_in);
    dsf <= 4'h0;
    gchk(4'h0);
    rchk("stat", OFS_STAT, 32'h3, RESP_OKAY);
    clr_b <= 1'b0;
    @(posedge clk_in);
    clr_b <= 1'b1;
    gchk(4'hF);
    rchk("diag", OFS_DIAG, 32'h1 << (DG_DSV + 1), RESP_OKAY);
    boot <= 2'h1;
    @(posedge clk_in);
    boot <= 2'h0;
    gchk(4'h0);
    rchk("diag", OFS_DIAG, 32'h1 << DG_BOOT, RESP_OKAY);
    gchk(4'hF);
    // stop clear: only the faulty fet latched off until switched on again
    wreg(OFS_CTRL, 32'h0);
    dsf <= 4'h1;
    @(posedge clk_in);
    dsf <= 4'h0;
    gchk(4'hE);
    rchk("stat", OFS_STAT, 32'hE10, RESP_OKAY);
    cmd <= 4'hE;
    @(posedge clk_in);
    cmd <= 4'hF;
    gchk(4'hF);
    rchk("diag", OFS_DIAG, 32'h1 << DG_DSV, RESP_OKAY);
    // masked diagnostic is silent, unmaskable ones still act
    wreg(OFS_MASK, 32'h1 << MK_DSV);
    wreg(OFS_CTRL, 32'h1);
    dsf <= 4'hF;
    gchk(4'hF);
    dsf <= 4'h0;
    rchk("diag", OFS_DIAG, 32'h0, RESP_OKAY);
    wreg(OFS_MASK, 32'hFFF);
    flt <= 5'h10;
    gchk(4'h0);
    flt <= 5'h01;
    gchk(4'h0);
    flt <= 5'h00;
    wreg(OFS_MASK, 32'h0);
    // state frozen while the clock enable is low
    ce <= 1'b0;
    flt <= 5'h10;
    gchk(4'hF);
    ce <= 1'b1;
    gchk(4'h0);
    flt <= 5'h00;
    gchk(4'hF);
    // off-line command, on-line results, unmapped place
    wreg(OFS_VCMD, 32'h5A);
    check("verify_cmd", {24'h0, vcmd}, 32'h5A);
    rchk("vres", OFS_VRES, 32'h3C, RESP_OKAY);
    u_ctl.wr(8'h20, 32'h1, resp);
    check("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rchk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
    summarize();
  end
endmodule
